// ==== iofi_pkg.sv ====
// Package: constants for the I/O module fault indicator
package iofi_pkg;
  localparam int IOFI_NUM_CH       = 64;
  localparam int IOFI_NUM_LAMP     = 32;
  localparam int IOFI_CLK_MHZ      = 100;
  // Blink half period in ms, turned into clock cycles
  localparam int IOFI_BLINK_HALF_MS = 250;
  localparam int IOFI_BLINK_CYC    = IOFI_BLINK_HALF_MS * 1000 * IOFI_CLK_MHZ;
  // Supply thresholds in volts, compared against a millivolt code
  localparam int IOFI_ACT_TH24_V   = 18;
  localparam int IOFI_ACT_TH48_V   = 36;
  localparam int IOFI_VOLT_W       = 16;
  localparam logic [IOFI_VOLT_W-1:0] IOFI_ACT_TH24_MV =
    IOFI_VOLT_W'(IOFI_ACT_TH24_V * 1000);
  localparam logic [IOFI_VOLT_W-1:0] IOFI_ACT_TH48_MV =
    IOFI_VOLT_W'(IOFI_ACT_TH48_V * 1000);
  localparam logic [1:0] IOFI_LAMP_OFF   = 2'h0;
  localparam logic [1:0] IOFI_LAMP_ON    = 2'h1;
  localparam logic [1:0] IOFI_LAMP_BLINK = 2'h3;
  typedef enum logic [1:0] {
    IOFI_TRIP_IDLE = 2'h0,
    IOFI_TRIP_ON   = 2'h1,
    IOFI_TRIP_OPEN = 2'h3
  } iofi_trip_t;
endpackage : iofi_pkg

// ==== iofi_out_chan.sv ====
// Module: one protected transistor output with trip latch
`timescale 1ns/1ns
module iofi_out_chan
  import iofi_pkg::*;
(
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic cmd,
  input  wire logic isProtected,
  input  wire logic overload,
  input  wire logic tripClear,
  input  wire logic forceOff,
  output logic      drive,
  output logic      tripped
);
  iofi_trip_t state_r;
  iofi_trip_t state_nxt;
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      IOFI_TRIP_IDLE:
        if (cmd)
          state_nxt = IOFI_TRIP_ON;
      IOFI_TRIP_ON:
      begin
        if (!cmd)
          state_nxt = IOFI_TRIP_IDLE;
        else if (isProtected && overload)
          state_nxt = IOFI_TRIP_OPEN;
      end
      IOFI_TRIP_OPEN:
        // Trip holds until cleared so a short cannot oscillate
        if (tripClear && !(cmd && overload))
          state_nxt = IOFI_TRIP_IDLE;
      default:
        state_nxt = IOFI_TRIP_IDLE;
    endcase
  end
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      state_r <= IOFI_TRIP_IDLE;
    else
      state_r <= state_nxt;
  end
  assign drive   = (state_r == IOFI_TRIP_ON) && !forceOff;
  assign tripped = (state_r == IOFI_TRIP_OPEN);
endmodule : iofi_out_chan

// ==== iofi_fault_indicator.sv ====
// Module: status and fault lamp driver for a discrete I/O module
`timescale 1ns/1ns
module iofi_fault_indicator
  import iofi_pkg::*;
#(
  parameter int NUM_CH    = IOFI_NUM_CH,
  parameter int NUM_LAMP  = IOFI_NUM_LAMP,
  parameter int BLINK_CYC = IOFI_BLINK_CYC
)
(
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  input  wire logic                   moduleFail,
  input  wire logic                   commError,
  input  wire logic                   configured,
  input  wire logic                   termMissing,
  input  wire logic                   sensorSupplyOk,
  input  wire logic [IOFI_VOLT_W-1:0] actSupplyMv,
  input  wire logic                   supply48,
  input  wire logic [NUM_CH-1:0]      inState,
  input  wire logic [NUM_CH-1:0]      chanError,
  input  wire logic [NUM_CH-1:0]      outCmd,
  input  wire logic [NUM_CH-1:0]      outProtected,
  input  wire logic [NUM_CH-1:0]      overload,
  input  wire logic [NUM_CH-1:0]      isOutput,
  input  wire logic                   tripClear,
  input  wire logic                   upperSelect,
  output logic                        runLamp,
  output logic                        errLamp,
  output logic                        ioLamp,
  output logic                        upperLamp,
  output logic [NUM_LAMP-1:0]         chanLamp,
  output logic [NUM_CH-1:0]           outDrive
);
  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: field signals are asynchronous to mclk
  logic [NUM_CH-1:0] inS1_r, inS2_r, ovS1_r, ovS2_r, ceS1_r, ceS2_r;
  logic [1:0]        fS1_r, fS2_r;
  logic              swS1_r, swS2_r;
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      inS1_r <= '0;
      inS2_r <= '0;
      ovS1_r <= '0;
      ovS2_r <= '0;
      ceS1_r <= '0;
      ceS2_r <= '0;
      // Supply starts as present so no false I/O lamp after reset
      fS1_r  <= 2'h1;
      fS2_r  <= 2'h1;
      swS1_r <= 1'b0;
      swS2_r <= 1'b0;
    end
    else
    begin
      inS1_r <= inState;
      inS2_r <= inS1_r;
      ovS1_r <= overload;
      ovS2_r <= ovS1_r;
      ceS1_r <= chanError;
      ceS2_r <= ceS1_r;
      fS1_r  <= {termMissing, sensorSupplyOk};
      fS2_r  <= fS1_r;
      swS1_r <= upperSelect;
      swS2_r <= swS1_r;
    end
  end
  logic termMiss, sensOk;
  assign termMiss = fS2_r[1];
  assign sensOk   = fS2_r[0];

  ////////////////////////////////////////////////////////////////////////
  // Shared blink generator
  // Wrap one below the period so each half lasts BLINK_CYC cycles
  localparam int CNT_W = $clog2(BLINK_CYC + 1);
  logic [CNT_W-1:0] blinkCnt_r, blinkCnt_nxt;
  logic             blink_r, blink_nxt;
  always_comb
  begin
    blinkCnt_nxt = blinkCnt_r + CNT_W'(1);
    blink_nxt    = blink_r;
    if (blinkCnt_r == CNT_W'(BLINK_CYC - 1))
    begin
      blinkCnt_nxt = '0;
      blink_nxt    = ~blink_r;
    end
  end
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      blinkCnt_r <= '0;
      blink_r    <= 1'b0;
    end
    else
    begin
      blinkCnt_r <= blinkCnt_nxt;
      blink_r    <= blink_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Actuator supply check and output channels
  logic actLow;
  assign actLow = supply48 ? (actSupplyMv <= IOFI_ACT_TH48_MV)
                           : (actSupplyMv <= IOFI_ACT_TH24_MV);
  logic [NUM_CH-1:0] tripped;
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++)
    begin : gChan
      iofi_out_chan uChan (
        .mclk        (mclk),
        .rst_n       (rst_n),
        .cmd         (outCmd[g] & isOutput[g]),
        .isProtected (outProtected[g]),
        .overload    (ovS2_r[g]),
        .tripClear   (tripClear),
        .forceOff    (actLow),
        .drive       (outDrive[g]),
        .tripped     (tripped[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Input image: frozen while sensor supply is lost
  logic [NUM_CH-1:0] image_r, image_nxt;
  always_comb
  begin
    image_nxt = image_r;
    if (sensOk)
      image_nxt = inS2_r;
  end
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      image_r <= '0;
    else
      image_r <= image_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // Lamp decoding, registered so all lamps change together
  logic [1:0]          runMode, errMode, ioMode;
  logic [NUM_CH-1:0]   chOn, chBlink;
  logic [NUM_LAMP-1:0] lamp_nxt;
  logic                run_nxt, err_nxt, io_nxt, upper_nxt;
  logic                anyTrip;
  assign anyTrip = |tripped;
  always_comb
  begin
    // Comm loss keeps run lit so the error flash tells it apart
    runMode = (!moduleFail && configured)
              ? IOFI_LAMP_ON : IOFI_LAMP_OFF;
    if (moduleFail)
      errMode = IOFI_LAMP_ON;
    else if (commError || !configured)
      errMode = IOFI_LAMP_BLINK;
    else
      errMode = IOFI_LAMP_OFF;
    if (anyTrip || actLow || !sensOk)
      ioMode = IOFI_LAMP_ON;
    else if (termMiss)
      ioMode = IOFI_LAMP_BLINK;
    else
      ioMode = IOFI_LAMP_OFF;
    // Outputs show actual drive; inputs show image
    chOn    = (isOutput & outDrive) | (~isOutput & image_r);
    // Unprotected outputs have no overload sensing
    chBlink = ceS2_r | tripped
              | (isOutput & outProtected & ovS2_r & outCmd);
    run_nxt = runMode[0];
    err_nxt = errMode[1] ? blink_r : errMode[0];
    io_nxt  = ioMode[1] ? blink_r : ioMode[0];
    // Upper group only exists on wide modules
    upper_nxt = (NUM_CH > NUM_LAMP) && swS2_r;
    for (int i = 0; i < NUM_LAMP; i++)
    begin
      if (upper_nxt && (i + NUM_LAMP < NUM_CH))
        lamp_nxt[i] = chBlink[i + NUM_LAMP] ? blink_r
                                            : chOn[i + NUM_LAMP];
      else if (i < NUM_CH)
        lamp_nxt[i] = chBlink[i] ? blink_r : chOn[i];
      else
        lamp_nxt[i] = 1'b0;
    end
  end
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      runLamp   <= 1'b0;
      errLamp   <= 1'b0;
      ioLamp    <= 1'b0;
      upperLamp <= 1'b0;
      chanLamp  <= '0;
    end
    else
    begin
      runLamp   <= run_nxt;
      errLamp   <= err_nxt;
      ioLamp    <= io_nxt;
      upperLamp <= upper_nxt;
      chanLamp  <= lamp_nxt;
    end
  end
endmodule : iofi_fault_indicator

// ==== iofi_fault_indicator_sva.sv ====
// Checker: port-level assertions for the fault indicator
`timescale 1ns/1ns
module iofi_fault_indicator_sva
  import iofi_pkg::*;
#(
  parameter int NUM_CH   = IOFI_NUM_CH,
  parameter int NUM_LAMP = IOFI_NUM_LAMP
)
(
  input wire logic                   mclk,
  input wire logic                   rst_n,
  input wire logic                   moduleFail,
  input wire logic [IOFI_VOLT_W-1:0] actSupplyMv,
  input wire logic                   supply48,
  input wire logic [NUM_CH-1:0]      outCmd,
  input wire logic                   upperSelect,
  input wire logic                   runLamp,
  input wire logic                   errLamp,
  input wire logic                   ioLamp,
  input wire logic                   upperLamp,
  input wire logic [NUM_LAMP-1:0]    chanLamp,
  input wire logic [NUM_CH-1:0]      outDrive
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic actOk;
  assign actOk = actSupplyMv >
    (supply48 ? IOFI_ACT_TH48_MV : IOFI_ACT_TH24_MV);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_fail_held;
    moduleFail [*3];
  endsequence
  sequence s_sel_held(b);
    (upperSelect == b) [*4];
  endsequence
  a_run_fail_off: assert property (s_fail_held |=> !runLamp)
    else $error("run lamp lit during failure");
  a_err_fail_lit: assert property (s_fail_held |=> errLamp)
    else $error("error lamp dark during failure");
  a_act_low_off: assert property ((!actOk) [*2] |-> outDrive == '0)
    else $error("outputs driven on low actuator supply");
  a_act_low_lamp: assert property ((!actOk) [*3] |=> ioLamp)
    else $error("io lamp dark on low actuator supply");
  a_drive_needs_cmd: assert property ((outDrive & ~$past(outCmd)) == '0)
    else $error("output driven without command");
  a_reset_all_dark: assert property (!$past(rst_n) |-> chanLamp == '0
    && !(runLamp | errLamp | ioLamp | upperLamp) && outDrive == '0)
    else $error("lamp or output active after reset");
  a_upper_sel_on: assert property (s_sel_held(1'b1) |=> upperLamp)
    else $error("upper lamp dark while upper group shown");
  a_upper_sel_off: assert property (s_sel_held(1'b0) |=> !upperLamp)
    else $error("upper lamp lit while lower group shown");
  a_trip_stays_off: assert property ($fell(outDrive[0]) && outCmd[0]
    && $past(outCmd[0]) && actOk |=> !outDrive[0])
    else $error("tripped output came back by itself");
endmodule : iofi_fault_indicator_sva
bind iofi_fault_indicator iofi_fault_indicator_sva #(.NUM_CH(NUM_CH),
  .NUM_LAMP(NUM_LAMP)) i_iofi_fault_indicator_sva (.*);

// ==== iofi_field_load.sv ====
// Partner: field loads on the outputs, shorted on request
`timescale 1ns/1ns
module iofi_field_load
  import iofi_pkg::*;
(
  input  wire logic [IOFI_NUM_CH-1:0] drive,
  input  wire logic                   mclk,
  input  wire logic [IOFI_NUM_CH-1:0] shortMask,
  output logic      [IOFI_NUM_CH-1:0] overload
);
  // Overcurrent flows only while the output sources current
  always_ff @(posedge mclk)
  begin
    overload <= drive & shortMask;
  end
endmodule : iofi_field_load

// ==== iofi_fault_indicator_tb.sv ====
// Testbench: directed scenarios for the fault indicator
`timescale 1ns/1ns
module iofi_fault_indicator_tb
  import iofi_pkg::*;
;
  logic mclk = 0, rst_n = 0, moduleFail = 0, commError = 0, configured = 1;
  logic termMissing = 0, sensorSupplyOk = 1, supply48 = 0, tripClear = 0;
  logic upperSelect = 0, runLamp, errLamp, ioLamp, upperLamp;
  logic [15:0] actSupplyMv = 16'h5dc0;
  logic [63:0] inState = '0, chanError = '0, outCmd = '0, shortMask = '0;
  logic [63:0] outProtected = 64'h1, isOutput = 64'hf, overload, outDrive;
  logic [31:0] chanLamp;
  int          bad_count = 0, checks = 0, cyc = 0;
  wire  [3:0]  lv = {chanLamp[2], chanLamp[0], ioLamp, errLamp};
  // Short blink period keeps lamp windows to a few cycles
  iofi_fault_indicator #(.BLINK_CYC(4)) i_iofi_fault_indicator (
    .mclk, .rst_n, .moduleFail, .commError, .configured, .termMissing,
    .sensorSupplyOk, .actSupplyMv, .supply48, .inState, .chanError,
    .outCmd, .outProtected, .overload, .isOutput, .tripClear,
    .upperSelect, .runLamp, .errLamp, .ioLamp, .upperLamp, .chanLamp,
    .outDrive);
  iofi_field_load i_iofi_field_load (.mclk, .drive(outDrive), .shortMask,
    .overload);
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 2000)
    begin
      bad_count = bad_count + 1;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks = checks + 1;
    if (s !== e)
    begin
      bad_count = bad_count + 1;
      $display("CHECK FAILED t=%0t seen %0h exp %0h", $time, s, e);
    end
  endtask : chk
  task automatic tk(input int n);
    repeat (n) @(posedge mclk);
  endtask : tk
  task automatic win(input int sel, output int hi, output int tg);
    logic p;
    hi = 0;
    tg = 0;
    @(negedge mclk);
    p = lv[sel];
    repeat (16)
    begin
      @(negedge mclk);
      hi = hi + lv[sel];
      tg = tg + (lv[sel] != p);
      p = lv[sel];
    end
  endtask : win
  ////////////////////////////////////////////////////////////////////////////
  task automatic s_status;
    int hi, tg;
    tk(5);
    @(negedge mclk);
    chk({runLamp, errLamp}, 2'h2);
    tk(1);
    moduleFail <= 1;
    tk(5);
    win(0, hi, tg);
    chk({hi == 16, runLamp}, 2'h2);
    tk(1);
    moduleFail <= 0;
    commError <= 1;
    tk(5);
    win(0, hi, tg);
    chk({tg > 1, runLamp}, 2'h3);
    tk(1);
    commError <= 0;
    configured <= 0;
    tk(5);
    win(0, hi, tg);
    chk({tg > 1, runLamp}, 2'h2);
    tk(1);
    configured <= 1;
  endtask : s_status
  task automatic s_io;
    int hi, tg;
    termMissing <= 1;
    inState <= 64'h30;
    tk(6);
    win(1, hi, tg);
    chk(tg > 1, 1);
    tk(1);
    termMissing <= 0;
    sensorSupplyOk <= 0;
    tk(6);
    inState <= 64'hc0;
    tk(6);
    win(1, hi, tg);
    chk({hi == 16, chanLamp[7:4]}, 5'h13);
    tk(1);
    sensorSupplyOk <= 1;
    tk(6);
    @(negedge mclk);
    chk(chanLamp[7:4], 4'hc);
  endtask : s_io
  task automatic s_chan;
    int hi, tg;
    tk(1);
    inState <= 64'h5 << 32;
    chanError <= 64'h4 << 32;
    upperSelect <= 1;
    tk(6);
    win(3, hi, tg);
    chk({upperLamp, chanLamp[0], tg > 1}, 3'h7);
    tk(1);
    upperSelect <= 0;
    tk(6);
    @(negedge mclk);
    chk({upperLamp, chanLamp[7:4]}, 5'h0);
  endtask : s_chan
  task automatic s_trip;
    int hi, tg;
    tk(1);
    outCmd <= 64'h3;
    shortMask <= 64'h3;
    chanError <= 64'h4;
    tk(8);
    win(2, hi, tg);
    chk({outDrive[1:0], ioLamp, tg > 1}, 4'hb);
    repeat (8)
    begin
      @(negedge mclk);
      chk(chanLamp[0], chanLamp[2]);
      chk(chanLamp[1], 1'b1);
    end
    tk(1);
    shortMask <= '0;
    tk(3);
    tripClear <= 1;
    tk(1);
    tripClear <= 0;
    tk(4);
    @(negedge mclk);
    chk(outDrive[0], 1);
  endtask : s_trip
  task automatic s_act;
    tk(1);
    actSupplyMv <= IOFI_ACT_TH24_MV;
    tk(5);
    @(negedge mclk);
    chk({outDrive[1:0], ioLamp}, 3'h1);
    tk(1);
    actSupplyMv <= IOFI_ACT_TH24_MV + 16'h1;
    tk(5);
    @(negedge mclk);
    chk(outDrive[1:0], 2'h3);
    tk(1);
    actSupplyMv <= IOFI_ACT_TH48_MV;
    supply48 <= 1;
    tk(5);
    @(negedge mclk);
    chk({outDrive[1:0], ioLamp}, 3'h1);
  endtask : s_act
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : final_report
  initial
  begin
    tk(10);
    rst_n <= 1;
    s_status();
    s_io();
    s_chan();
    s_trip();
    s_act();
    final_report();
  end
endmodule : iofi_fault_indicator_tb
